// ---- ddsc_regs.vh ----
`ifndef DDSC_REGS_VH
`define DDSC_REGS_VH

// register byte offsets on the bus
`define DDSC_OFF_CTRL1 5'h00
`define DDSC_OFF_CTRL2 5'h04
`define DDSC_OFF_TUNE 5'h08
`define DDSC_OFF_UPDATE 5'h0C
`define DDSC_OFF_STATUS 5'h10

// register addresses seen by the serial port
`define DDSC_SER_CTRL1 5'h00
`define DDSC_SER_CTRL2 5'h01
`define DDSC_SER_TUNE 5'h04

// control_reg_one fields
`define DDSC_C1_CLK_STOP 4
`define DDSC_C1_LSB_FIRST 8
`define DDSC_C1_SDIO_IN_ONLY 9
`define DDSC_C1_CLR_PHASE 10
`define DDSC_C1_AUTO_CLR 13
`define DDSC_C1_MASK 32'h0000_2710

// control_reg_two fields
`define DDSC_C2_MULT_LO 3
`define DDSC_C2_MULT_HI 7
`define DDSC_C2_XTAL_OUT 9
`define DDSC_C2_MASK 32'h0000_02F8

// reset values: working phase-clear bit set, its buffer clear
`define DDSC_BUF_RESET 32'h0000_0000
`define DDSC_C1_ACTIVE_RESET 32'h0000_0400

// multiplier range that runs the loop
`define DDSC_MULT_MIN 5'h04
`define DDSC_MULT_MAX 5'h14
`define DDSC_MULT_BYPASS 5'h01

// serial frame: instruction byte then one 32-bit word
`define DDSC_SER_INSTR_LAST 6'h07
`define DDSC_SER_LAST_BIT 6'h27
`define DDSC_SER_READ_BIT 7

// bus responses
`define DDSC_RESP_OKAY 2'h0
`define DDSC_RESP_SLVERR 2'h2

`endif

// ---- ddsc_cos.v ----
`timescale 1ns/1ps
`include "ddsc_regs.vh"

module ddsc_cos
(
  input wire clk_i,
  input wire reset_i,
  input wire [31:0] phase_i,
  output reg [13:0] sample_o
);

  // cosine is sine a quarter turn ahead; top 14 phase bits used
  wire [13:0] turn = phase_i[31:18] + 14'h1000;
  wire [12:0] pos = turn[12:0];
  wire [13:0] rest = 14'h2000 - {1'b0, pos};
  wire [26:0] prod = {14'h0000, pos} * {13'h0000, rest};
  // parabola 4x(1-x) stands in for the half sine: cheap, about 5.6 percent error
  wire [15:0] amp_raw = prod[26:11];
  wire [12:0] amp = (amp_raw > 16'h1FFF) ? 13'h1FFF : amp_raw[12:0];

  ////////////////////////////////////////////////////////////////////////////
  // offset-binary sample for the converter, registered
  always @(posedge clk_i)
  begin
    if (reset_i)
      sample_o <= 14'h2000;
    else if (turn[13])
      sample_o <= 14'h2000 - {1'b0, amp};
    else
      sample_o <= 14'h2000 + {1'b0, amp};
  end

endmodule // ddsc_cos

// ---- ddsc_serial.v ----
`timescale 1ns/1ps
`include "ddsc_regs.vh"

module ddsc_serial
(
  input wire clk_i,
  input wire reset_i,
  input wire sclk_i,
  input wire sdio_i,
  input wire cs_n_i,
  input wire port_resync_input_i,
  input wire lsb_first_i,
  input wire sdio_input_only_i,
  input wire [31:0] rd_data_i,
  output wire [4:0] addr_o,
  output reg wr_o,
  output reg [31:0] wr_data_o,
  output reg serial_data_output_o,
  output wire sdio_o,
  output wire sdio_oe_n_o
);

  // bit 0 sclk, 1 data, 2 select, 3 resync; select idles high
  localparam [3:0] SYNC_RESET = 4'b0100;
  wire [3:0] raw = {port_resync_input_i, cs_n_i, sdio_i, sclk_i};
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg [3:0] s3_r;
  reg [3:0] filt_r;
  reg [5:0] cnt_r;
  reg [7:0] instr_r;
  reg [31:0] shin_r;
  reg [31:0] shout_r;
  reg reading_r;
  reg load_r;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; a level counts once stages 2 and 3 agree
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_sync
      always @(posedge clk_i)
      begin
        if (reset_i)
        begin
          s1_r[i] <= SYNC_RESET[i];
          s2_r[i] <= SYNC_RESET[i];
          s3_r[i] <= SYNC_RESET[i];
          filt_r[i] <= SYNC_RESET[i];
        end
        else
        begin
          s1_r[i] <= raw[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i])
            filt_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate

  wire sclk_rise = s2_r[0] & s3_r[0] & ~filt_r[0];
  wire sclk_fall = ~s2_r[0] & ~s3_r[0] & filt_r[0];
  // resync high aborts like deselect; select low required
  wire active = ~filt_r[2] & ~filt_r[3];
  wire bit_in = filt_r[1];
  wire [7:0] instr_nxt = lsb_first_i ? {bit_in, instr_r[7:1]} : {instr_r[6:0], bit_in};
  wire [31:0] shin_nxt = lsb_first_i ? {bit_in, shin_r[31:1]} : {shin_r[30:0], bit_in};

  assign addr_o = instr_r[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // frame: instruction byte, then a 32-bit word, either order
  always @(posedge clk_i)
  begin
    wr_o <= 1'b0;
    if (reset_i)
    begin
      cnt_r <= 6'h00;
      instr_r <= 8'h00;
      shin_r <= 32'h0000_0000;
      shout_r <= 32'h0000_0000;
      reading_r <= 1'b0;
      load_r <= 1'b0;
      wr_data_o <= 32'h0000_0000;
      serial_data_output_o <= 1'b0;
    end
    else if (!active)
    begin
      cnt_r <= 6'h00; // abort anything in progress
      reading_r <= 1'b0;
      load_r <= 1'b0;
    end
    else
    begin
      load_r <= 1'b0;
      if (load_r)
        shout_r <= rd_data_i;
      if (sclk_rise && cnt_r <= `DDSC_SER_LAST_BIT)
      begin
        cnt_r <= cnt_r + 6'h01;
        if (cnt_r <= `DDSC_SER_INSTR_LAST)
        begin
          instr_r <= instr_nxt;
          if (cnt_r == `DDSC_SER_INSTR_LAST)
          begin
            reading_r <= instr_nxt[`DDSC_SER_READ_BIT];
            load_r <= instr_nxt[`DDSC_SER_READ_BIT];
          end
        end
        else
        begin
          shin_r <= shin_nxt;
          if (cnt_r == `DDSC_SER_LAST_BIT && !reading_r)
          begin
            wr_o <= 1'b1;
            wr_data_o <= shin_nxt;
          end
        end
      end
      // read bits change on the fall, stable at the next rise
      if (sclk_fall && reading_r)
      begin
        serial_data_output_o <= lsb_first_i ? shout_r[0] : shout_r[31];
        shout_r <= lsb_first_i ? {1'b0, shout_r[31:1]} : {shout_r[30:0], 1'b0};
      end
    end
  end

  // 2-wire turns the data pin round for reads; 3-wire keeps it input
  assign sdio_o = serial_data_output_o;
  assign sdio_oe_n_o = ~(reading_r & active & ~sdio_input_only_i);

endmodule // ddsc_serial

// ---- ddsc_core.v ----
// What this block does
// - 32-bit phase accumulator stepped by tuning word; upper words alias.
// - accumulator phase becomes a cosine amplitude for the 14-bit converter.
// - a zero tuning word holds the present phase, no return to zero.
// - the phase-clear control bit forces accumulator output to zero phase.
// - after reset working clear bit is one, its buffer zero, until update.
// - pll multiplier comes from bits 7 to 3 of control register two.
// - multiplier values 4 through 20 multiply the reference by that value.
// - other multiplier values bypass and power down the pll.
// - oscillator select high enables the crystal oscillator, low disables it.
// - control register one bit 4 stops the clock, oscillator stays powered.
// - control register two bit 9 enables the crystal output buffer while oscillator select is high.
// - serial port reads and writes both control registers and the tuning word, msb or lsb first.
// - serial port works 2-wire with shared data pin or 3-wire.
// - two optional serial inputs: port resync and device select.
// - resync high aborts the transfer; a new one starts once it falls.
// - device select is active low; traffic is ignored while deselected.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ddsc_regs.vh"

module ddsc_core
#(
  parameter ADDR_W = 5
)
(
  input wire clk_i,
  input wire reset_i,
  // axi4-lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // serial control port pins
  input wire sclk_i,
  input wire sdio_i,
  output wire sdio_o,
  output wire sdio_oe_n_o,
  output wire serial_data_output_o,
  input wire cs_n_i,
  input wire port_resync_input_i,
  // clock section
  input wire oscillator_select_pin_i,
  output reg oscillator_enable_o,
  output reg crystal_out_enable_o,
  output reg clock_buffer_enable_o,
  output reg pll_enable_o,
  output reg [4:0] pll_multiplier_o,
  // converter sample
  output wire [13:0] dac_sample_o
);

  reg [31:0] buf_ctrl1_r;
  reg [31:0] buf_ctrl2_r;
  reg [31:0] buf_tune_r;
  reg [31:0] control_reg_one_r;
  reg [31:0] control_reg_two_r;
  reg [31:0] tuning_word_r;
  reg [31:0] phase_acc_r;
  reg aw_held_r;
  reg w_held_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg osel_s1_r;
  reg osel_s2_r;
  reg osel_s3_r;
  reg osel_r;
  reg [31:0] axi_rd_data;
  reg axi_rd_hit;
  reg [31:0] ser_rd_data;
  wire [4:0] ser_addr;
  wire ser_wr;
  wire [31:0] ser_wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken independently
  wire do_write = aw_held_r & w_held_r & ~s_axi_bvalid_o;
  wire wr_ctrl1 = do_write && awaddr_r == `DDSC_OFF_CTRL1;
  wire wr_ctrl2 = do_write && awaddr_r == `DDSC_OFF_CTRL2;
  wire wr_tune = do_write && awaddr_r == `DDSC_OFF_TUNE;
  wire wr_update = do_write && awaddr_r == `DDSC_OFF_UPDATE;
  wire wr_known = wr_ctrl1 | wr_ctrl2 | wr_tune | wr_update | 
                  (do_write && awaddr_r == `DDSC_OFF_STATUS);

  assign s_axi_awready_o = ~aw_held_r;
  assign s_axi_wready_o = ~w_held_r;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `DDSC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_held_r)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr_i[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid_i && !w_held_r)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_known ? `DDSC_RESP_OKAY : `DDSC_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode; software sees buffered values
  always @*
  begin
    axi_rd_hit = 1'b1;
    case ({s_axi_araddr_i[ADDR_W-1:2], 2'b00})
      `DDSC_OFF_CTRL1: axi_rd_data = buf_ctrl1_r;
      `DDSC_OFF_CTRL2: axi_rd_data = buf_ctrl2_r;
      `DDSC_OFF_TUNE: axi_rd_data = buf_tune_r;
      `DDSC_OFF_UPDATE: axi_rd_data = 32'h0000_0000;
      `DDSC_OFF_STATUS: axi_rd_data = {phase_acc_r[31:16], 3'h0, pll_multiplier_o,
                                       4'h0, control_reg_one_r[`DDSC_C1_CLR_PHASE],
                                       clock_buffer_enable_o, oscillator_enable_o,
                                       pll_enable_o};
      default:
      begin
        axi_rd_data = 32'h0000_0000;
        axi_rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready_o = ~s_axi_rvalid_o;

  // read channel: one read in flight, answered the cycle after it is taken
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `DDSC_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !s_axi_rvalid_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= axi_rd_data;
      s_axi_rresp_o <= axi_rd_hit ? `DDSC_RESP_OKAY : `DDSC_RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial port; it shares the buffers with the bus
  always @*
  begin
    case (ser_addr)
      `DDSC_SER_CTRL1: ser_rd_data = buf_ctrl1_r;
      `DDSC_SER_CTRL2: ser_rd_data = buf_ctrl2_r;
      `DDSC_SER_TUNE: ser_rd_data = buf_tune_r;
      default: ser_rd_data = 32'h0000_0000;
    endcase
  end

  ddsc_serial u_serial
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sclk_i(sclk_i),
    .sdio_i(sdio_i),
    .cs_n_i(cs_n_i),
    .port_resync_input_i(port_resync_input_i),
    .lsb_first_i(control_reg_one_r[`DDSC_C1_LSB_FIRST]),
    .sdio_input_only_i(control_reg_one_r[`DDSC_C1_SDIO_IN_ONLY]),
    .rd_data_i(ser_rd_data),
    .addr_o(ser_addr),
    .wr_o(ser_wr),
    .wr_data_o(ser_wr_data),
    .serial_data_output_o(serial_data_output_o),
    .sdio_o(sdio_o),
    .sdio_oe_n_o(sdio_oe_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // buffers; a bus write beats a same-cycle serial write
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      buf_ctrl1_r <= `DDSC_BUF_RESET; // buffered clear bit starts at zero
      buf_ctrl2_r <= `DDSC_BUF_RESET;
      buf_tune_r <= `DDSC_BUF_RESET;
    end
    else if (do_write)
    begin
      if (wr_ctrl1)
        buf_ctrl1_r <= merge(buf_ctrl1_r, wdata_r, wstrb_r) & `DDSC_C1_MASK;
      if (wr_ctrl2)
        buf_ctrl2_r <= merge(buf_ctrl2_r, wdata_r, wstrb_r) & `DDSC_C2_MASK;
      if (wr_tune)
        buf_tune_r <= merge(buf_tune_r, wdata_r, wstrb_r);
    end
    else if (ser_wr)
    begin
      if (ser_addr == `DDSC_SER_CTRL1)
        buf_ctrl1_r <= ser_wr_data & `DDSC_C1_MASK;
      if (ser_addr == `DDSC_SER_CTRL2)
        buf_ctrl2_r <= ser_wr_data & `DDSC_C2_MASK;
      if (ser_addr == `DDSC_SER_TUNE)
        buf_tune_r <= ser_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working registers change only on the update strobe
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      control_reg_one_r <= `DDSC_C1_ACTIVE_RESET; // clear held until first update
      control_reg_two_r <= `DDSC_BUF_RESET;
      tuning_word_r <= `DDSC_BUF_RESET;
    end
    else if (wr_update)
    begin
      control_reg_one_r <= buf_ctrl1_r;
      control_reg_two_r <= buf_ctrl2_r;
      tuning_word_r <= buf_tune_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase accumulator; clock stop freezes it, clear still wins
  wire clock_stopped = control_reg_one_r[`DDSC_C1_CLK_STOP];
  wire auto_clear = wr_update & buf_ctrl1_r[`DDSC_C1_AUTO_CLR];
  wire phase_clear = control_reg_one_r[`DDSC_C1_CLR_PHASE] | auto_clear;

  always @(posedge clk_i)
  begin
    if (reset_i)
      phase_acc_r <= 32'h0000_0000;
    else if (phase_clear)
      phase_acc_r <= 32'h0000_0000; // forced to zero phase
    else if (!clock_stopped)
      phase_acc_r <= phase_acc_r + tuning_word_r; // wraps modulo 2^32
  end

  // cosine conversion for the converter
  ddsc_cos u_cos
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .phase_i(phase_acc_r),
    .sample_o(dac_sample_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // oscillator select pin, three-stage filter
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      osel_s1_r <= 1'b0;
      osel_s2_r <= 1'b0;
      osel_s3_r <= 1'b0;
      osel_r <= 1'b0;
    end
    else
    begin
      osel_s1_r <= oscillator_select_pin_i;
      osel_s2_r <= osel_s1_r;
      osel_s3_r <= osel_s2_r;
      if (osel_s2_r == osel_s3_r)
        osel_r <= osel_s3_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock section controls; the loop multiplier ignores the clock stop bit
  wire [4:0] mult = control_reg_two_r[`DDSC_C2_MULT_HI:`DDSC_C2_MULT_LO];
  wire mult_in_range = (mult >= `DDSC_MULT_MIN) && (mult <= `DDSC_MULT_MAX);

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      oscillator_enable_o <= 1'b0;
      crystal_out_enable_o <= 1'b0;
      clock_buffer_enable_o <= 1'b1;
      pll_enable_o <= 1'b0;
      pll_multiplier_o <= `DDSC_MULT_BYPASS;
    end
    else
    begin
      oscillator_enable_o <= osel_r; // stays on while clock stopped
      crystal_out_enable_o <= osel_r & control_reg_two_r[`DDSC_C2_XTAL_OUT];
      clock_buffer_enable_o <= ~clock_stopped;
      pll_enable_o <= mult_in_range; // out of range powers it down
      pll_multiplier_o <= mult_in_range ? mult : `DDSC_MULT_BYPASS;
    end
  end

endmodule // ddsc_core

// ---- ddsc_asserts.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bus answers, clock controls, serial pin drive
module ddsc_asserts
(
  input wire clk_i,
  input wire reset_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire cs_n_i,
  input wire sdio_oe_n_o,
  input wire oscillator_select_pin_i,
  input wire oscillator_enable_o,
  input wire crystal_out_enable_o,
  input wire pll_enable_o,
  input wire [4:0] pll_multiplier_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  // write answered once address and data are in
  sequence s_both_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_b_answer;
    ##[1:3] s_axi_bvalid_o;
  endsequence
  a_write_answer: assert property (s_both_taken |-> s_b_answer)
    else $error("write answer missing");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer dropped");
  // loop on only inside the range; bypass shows one
  a_mult_range: assert property (pll_enable_o |-> pll_multiplier_o >= 5'h04 &&
    pll_multiplier_o <= 5'h14) else $error("loop on outside range");
  a_bypass_one: assert property (!pll_enable_o |-> pll_multiplier_o == 5'h01)
    else $error("bypass multiplier wrong");
  // synchronised pin: a settled level gets six cycles
  a_osc_on: assert property (oscillator_select_pin_i [*6] |=> oscillator_enable_o)
    else $error("oscillator not enabled");
  a_osc_off: assert property (!oscillator_select_pin_i [*6] |=>
    !oscillator_enable_o && !crystal_out_enable_o) else $error("oscillator not off");
  a_sdio_quiet: assert property (cs_n_i [*6] |=> sdio_oe_n_o)
    else $error("data pin driven while deselected");
endmodule // ddsc_asserts

// ---- ddsc_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// serial host: clock idles low, data moves while it is low
module ddsc_host
(
  input wire clk_i,
  input wire sdio_i,
  input wire sdo_i,
  output logic sclk_o = 1'b0,
  output logic sdio_o = 1'b0,
  output logic sdio_en_o = 1'b0,
  output logic cs_n_o = 1'b1,
  output logic resync_o = 1'b0
);
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one frame; stop below 40 aborts by resync; half period 10 clocks
  task automatic frame(input [7:0] ins, input [31:0] d, input lsb, input two,
    input sel, input int stop, output logic [31:0] r);
    int k;
    r = 32'h0000_0000;
    @(posedge clk_i);
    cs_n_o <= !sel;
    for (int i = 0; i < 40; i++)
    begin
      if (i == stop)
      begin
        resync_o <= 1'b1;
        wt(8);
        resync_o <= 1'b0;
        break;
      end
      k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : 39 - i);
      sdio_en_o <= !(ins[7] && i >= 8); // released for read data
      sdio_o <= (i < 8) ? ins[k] : d[k];
      wt(10);
      sclk_o <= 1'b1;
      wt(10);
      if (i >= 8)
        r[k] = two ? sdio_i : sdo_i;
      sclk_o <= 1'b0;
    end
    wt(10);
    cs_n_o <= 1'b1;
    sdio_en_o <= 1'b0;
    wt(10);
  endtask
endmodule // ddsc_host

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "ddsc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic clk_i = 1'b0, reset_i = 1'b1, osc_pin = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00, m;
  logic [31:0] wdata = 32'h0000_0000, r1, r2, tw, d1;
  logic [65:0] expq[$], ent;
  logic [4:0] mlist [7] = '{5'h00, 5'h03, 5'h04, 5'h14, 5'h15, 5'h1F, 5'h0B};
  wire awready, wready, bvalid, arready, rvalid, sdio_o, sdio_oe_n, serial_data_output, sdio_w;
  wire oscen, xtal, clkbuf, pllen, sclk, cs_n, resync, h_d, h_en;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] mult;
  wire [13:0] dac;
  int n_errors = 0, num_checks = 0, cyc = 0, c1, c2, k;
  // released data pin toggles, never a stale level
  assign sdio_w = !sdio_oe_n ? sdio_o : (h_en ? h_d : cyc[0]);
  always #5 clk_i = ~clk_i;
  ddsc_core dut_u (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .sclk_i(sclk), .sdio_i(sdio_w), .sdio_o(sdio_o),
    .sdio_oe_n_o(sdio_oe_n), .serial_data_output_o(serial_data_output), .cs_n_i(cs_n),
    .port_resync_input_i(resync), .oscillator_select_pin_i(osc_pin),
    .oscillator_enable_o(oscen), .crystal_out_enable_o(xtal), .clock_buffer_enable_o(clkbuf),
    .pll_enable_o(pllen), .pll_multiplier_o(mult), .dac_sample_o(dac));
  ddsc_host host_u (.clk_i(clk_i), .sdio_i(sdio_w), .sdo_i(serial_data_output), .sclk_o(sclk),
    .sdio_o(h_d), .sdio_en_o(h_en), .cs_n_o(cs_n), .resync_o(resync));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input bit ok, input string s);
    num_checks++;
    if (!ok)
    begin
      n_errors++;
      $display("Error at %0t: %s", $time, s);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // aw and w offered together, each dropped once taken
  task wr(input [4:0] a, input [31:0] d, input [1:0] er);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk_i); while (!bvalid);
    bready <= 1'b0;
    chk(bresp === er, "write response");
  endtask
  task cfg(input [4:0] a, input [31:0] d);
    wr(a, d, `DDSC_RESP_OKAY);
    wr(`DDSC_OFF_UPDATE, 32'h0000_0000, `DDSC_RESP_OKAY);
  endtask
  // read notes its expectation; c = cycle the address was taken
  task rd(input [4:0] a, input [31:0] e, input [31:0] mk, input [1:0] er,
    output logic [31:0] v, output int c);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    expq.push_back({mk, er, e});
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    c = cyc;
    do @(posedge clk_i); while (!rvalid);
    rready <= 1'b0;
    v = rdata;
  endtask
  // oldest note vs each read answer
  always @(posedge clk_i)
    if (rvalid && rready && expq.size() > 0)
    begin
      ent = expq.pop_front();
      chk((((rdata ^ ent[31:0]) & ent[65:34]) === 32'h0) && (rresp === ent[33:32]), "read");
    end
  // watchdog, well past the run's length
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    k = $urandom(48);
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(clkbuf === 1'b1 && mult === 5'h01 && pllen === 1'b0, "reset outputs");
    rd(`DDSC_OFF_STATUS, 32'hE, 32'hFFFF_000F, `DDSC_RESP_OKAY, r1, c1);
    tw = $urandom_range(255, 1) << 16;
    wr(`DDSC_OFF_TUNE, tw, `DDSC_RESP_OKAY);
    rd(`DDSC_OFF_STATUS, 32'hE, 32'hFFFF_000F, `DDSC_RESP_OKAY, r1, c1);
    wr(`DDSC_OFF_UPDATE, 32'h0000_0000, `DDSC_RESP_OKAY);
    rd(`DDSC_OFF_STATUS, 32'h6, 32'hF, `DDSC_RESP_OKAY, r1, c1);
    rd(`DDSC_OFF_STATUS, 32'h0, 32'h0, `DDSC_RESP_OKAY, r2, c2);
    chk(r2[31:16] - r1[31:16] === 16'(tw[23:16] * (c2 - c1)), "phase step");
    cfg(`DDSC_OFF_CTRL1, 32'h0000_0400);
    rd(`DDSC_OFF_STATUS, 32'h8, 32'hFFFF_0008, `DDSC_RESP_OKAY, r1, c1);
    chk(dac[13] === 1'b1, "zero phase sample");
    // half-range word, then zero word: phase holds at 0 or half
    wr(`DDSC_OFF_TUNE, 32'h8000_0000, `DDSC_RESP_OKAY);
    cfg(`DDSC_OFF_CTRL1, 32'h0000_0000);
    cfg(`DDSC_OFF_TUNE, 32'h0000_0000);
    rd(`DDSC_OFF_STATUS, 32'h0, 32'h0, `DDSC_RESP_OKAY, r1, c1);
    repeat (5) @(posedge clk_i);
    rd(`DDSC_OFF_STATUS, r1, 32'hFFFF_0000, `DDSC_RESP_OKAY, r2, c2);
    chk(r1[30:16] === 15'h0 && dac[13] === !r1[31], "half step sample");
    // no lock wait modelled; products stay in range
    foreach (mlist[i])
    begin
      m = mlist[i];
      cfg(`DDSC_OFF_CTRL2, {22'h0, m[0], 1'b0, m, 3'h0});
      repeat (2) @(posedge clk_i);
      k = (m >= `DDSC_MULT_MIN && m <= `DDSC_MULT_MAX);
      chk(pllen === k[0] && mult === (k ? m : 5'h01) && xtal === m[0], "pll");
    end
    cfg(`DDSC_OFF_CTRL1, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    chk(clkbuf === 1'b0 && oscen === 1'b1, "clock stop");
    osc_pin <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(oscen === 1'b0 && xtal === 1'b0, "oscillator off");
    osc_pin <= 1'b1;
    cfg(`DDSC_OFF_CTRL1, 32'h0000_0000);
    repeat (8) @(posedge clk_i);
    chk(clkbuf === 1'b1 && oscen === 1'b1, "clock on");
    wr(5'h14, 32'hFFFF_FFFF, `DDSC_RESP_SLVERR);
    rd(5'h14, 32'h0, 32'hFFFF_FFFF, `DDSC_RESP_SLVERR, r1, c1);
    // serial: msb write, 3-wire read, 2-wire lsb read, abort, deselect
    d1 = $urandom;
    host_u.frame(8'h04, d1, 1'b0, 1'b0, 1'b1, 40, r1);
    rd(`DDSC_OFF_TUNE, d1, 32'hFFFF_FFFF, `DDSC_RESP_OKAY, r1, c1);
    cfg(`DDSC_OFF_CTRL1, 32'h0000_0200);
    host_u.frame(8'h84, 32'h0, 1'b0, 1'b0, 1'b1, 40, r1);
    chk(r1 === d1, "3-wire read");
    cfg(`DDSC_OFF_CTRL1, 32'h0000_0100);
    host_u.frame(8'h84, 32'h0, 1'b1, 1'b1, 1'b1, 40, r1);
    chk(r1 === d1, "2-wire read");
    host_u.frame(8'h04, ~d1, 1'b1, 1'b1, 1'b1, 20, r1);
    host_u.frame(8'h04, ~d1, 1'b1, 1'b1, 1'b0, 40, r1);
    rd(`DDSC_OFF_TUNE, d1, 32'hFFFF_FFFF, `DDSC_RESP_OKAY, r1, c1);
    host_u.frame(8'h04, ~d1, 1'b1, 1'b1, 1'b1, 40, r1);
    rd(`DDSC_OFF_TUNE, ~d1, 32'hFFFF_FFFF, `DDSC_RESP_OKAY, r1, c1);
    print_verdict;
  end
endmodule // testbench
bind ddsc_core ddsc_asserts chk_u (.clk_i(clk_i), .reset_i(reset_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .cs_n_i(cs_n_i), .sdio_oe_n_o(sdio_oe_n_o),
  .oscillator_select_pin_i(oscillator_select_pin_i), .oscillator_enable_o(oscillator_enable_o),
  .crystal_out_enable_o(crystal_out_enable_o), .pll_enable_o(pll_enable_o),
  .pll_multiplier_o(pll_multiplier_o));
